//--- src/lsl_consts.svh
// constants of the led driver serial loader: widths, field positions, reset values
// assumes inclusion by bare name from the package and the design modules
`ifndef LSL_CONSTS_SVH
`define LSL_CONSTS_SVH

`define LSL_CHANNELS 16
`define LSL_DC_BITS 6
`define LSL_GS_BITS 12
`define LSL_GS_PACKET_BITS 192
`define LSL_DC_PACKET_BITS 96
`define LSL_DC_RESET 6'h3f
`define LSL_GS_RESET 12'hfff
`define LSL_ST_OPEN_HI 191
`define LSL_ST_OPEN_LO 176
`define LSL_ST_TEF_BIT 175
`define LSL_ST_TWF_BIT 174
`define LSL_ST_DC_HI 167
`define LSL_ST_DC_LO 72
`define LSL_ST_OPEN2_HI 31
`define LSL_ST_OPEN2_LO 16
`define LSL_ST_SHORT_HI 15
`define LSL_ST_SHORT_LO 0

`endif

//--- src/lsl_pkg.sv
// types shared by the led driver serial loader
// assumes lsl_consts.svh on the include path
`include "lsl_consts.svh"
package lsl_pkg;
    typedef enum logic [0:0] {
        LSL_MODE_GS = 1'b0,
        LSL_MODE_DC = 1'b1
    } lsl_mode_t;
    typedef logic [`LSL_GS_PACKET_BITS-1:0] lsl_shift_t;
    typedef logic [`LSL_DC_PACKET_BITS-1:0] lsl_dc_all_t;
    typedef logic [`LSL_CHANNELS*`LSL_GS_BITS-1:0] lsl_gs_all_t;
endpackage

//--- src/lsl_sync.sv
// two flip-flop synchroniser for a bus of levels
// assumes the inputs are quasi-static or change one bit at a time
module lsl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    // first stage feeds only the second
    always_comb begin
        next_meta = d_i;
        next_q = meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end
endmodule

//--- src/lsl_regs.sv
// latched dot-correction and greyscale registers, loaded whole on a strobe
// assumes strobes are one-cycle pulses on clk_i
`include "lsl_consts.svh"
module lsl_regs (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_gs_i,
    input wire logic load_dc_i,
    input wire lsl_pkg::lsl_gs_all_t gs_data_i,
    input wire lsl_pkg::lsl_dc_all_t dc_data_i,
    output lsl_pkg::lsl_gs_all_t greyscale_value_o,
    output lsl_pkg::lsl_dc_all_t dot_correction_value_o
);
    import lsl_pkg::*;
    lsl_gs_all_t next_gs;
    lsl_dc_all_t next_dc;

    // all channels change together
    always_comb begin
        next_gs = load_gs_i ? gs_data_i : greyscale_value_o;
        next_dc = load_dc_i ? dc_data_i : dot_correction_value_o;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            greyscale_value_o <= {`LSL_CHANNELS{`LSL_GS_RESET}};
            dot_correction_value_o <= {`LSL_CHANNELS{`LSL_DC_RESET}};
        end else begin
            greyscale_value_o <= next_gs;
            dot_correction_value_o <= next_dc;
        end
    end
endmodule

//--- src/lsl_loader.sv
// serial loader of a 16-channel led driver: shift register on the serial
// clock, latch into greyscale or dot-correction registers, status readback
// assumes shift_clk_i is the controller's serial clock, unrelated to clk_i;
// latch_strobe_i, mode_i and the fault flags are asynchronous pins;
// the serial clock stands still while the latch strobe is high
`include "lsl_consts.svh"

// Functional notes
// - mode low: shift register is 192 bits of greyscale data
// - after reset: greyscale mode, shift register cleared
// - reset values: dot correction 63, greyscale 4095 on every channel
// - sixteen separate 6-bit dot-correction values, 0 to 63
// - all sixteen dot-correction values update together
// - sixteen separate 12-bit greyscale values, 0 off, 4095 full
// - latch rise in greyscale mode copies whole packet to greyscale
// - after greyscale latch shift register reloads with status packet
// - 192-bit status with flags and dot-correction copy, greyscale only
// - open flags at 191:176 and again at 31:16
// - thermal error bit 175, thermal warning bit 174
// - dot-correction copy in status bits 167:72
// - short flags in 15:0, other bits reserved, here zero
// - serial input shifts in on each rising serial clock edge except the one that reloads the status packet
// - latch rise in dot-correction mode loads dot-correction registers
// - shift register output drives serial output for chaining
module lsl_loader #(
    parameter int CHANNELS = `LSL_CHANNELS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic shift_clk_i,
    input wire logic serial_in_i,
    input wire logic latch_strobe_i,
    input wire logic mode_i,
    input wire logic [CHANNELS-1:0] open_led_flags_i,
    input wire logic [CHANNELS-1:0] short_led_flags_i,
    input wire logic thermal_error_flag_i,
    input wire logic thermal_warning_flag_i,
    output logic serial_out_o,
    output lsl_pkg::lsl_gs_all_t greyscale_value_o,
    output lsl_pkg::lsl_dc_all_t dot_correction_value_o,
    output lsl_pkg::lsl_mode_t mode_o
);
    import lsl_pkg::*;

    // core domain (clk_i)
    logic latch_s;
    logic mode_s;
    logic [CHANNELS-1:0] open_s;
    logic [CHANNELS-1:0] short_s;
    logic tef_s;
    logic twf_s;
    logic latch_prev;
    logic next_latch_prev;
    logic latch_rise;
    logic load_gs;
    logic load_dc;
    lsl_mode_t next_mode;
    lsl_shift_t snap_shift;
    lsl_shift_t next_snap_shift;
    lsl_shift_t status_word;
    lsl_shift_t status_hold;
    lsl_shift_t next_status_hold;
    logic reload_tgl;
    logic next_reload_tgl;
    logic snap_busy;
    logic next_snap_busy;
    logic snap_mode;
    logic next_snap_mode;

    // link domain (shift_clk_i)
    lsl_shift_t shift_reg;
    lsl_shift_t next_shift_reg;
    logic reload_s;
    logic reload_seen;
    logic next_reload_seen;

    // pins into the core domain through two flops
    lsl_sync #(.WIDTH(2 * CHANNELS + 4)) u_sync_pins (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({latch_strobe_i, mode_i, open_led_flags_i, short_led_flags_i,
              thermal_error_flag_i, thermal_warning_flag_i}),
        .q_o({latch_s, mode_s, open_s, short_s, tef_s, twf_s})
    );

    // reload toggle into the link domain; status_hold is quiet meanwhile
    lsl_sync #(.WIDTH(1)) u_sync_link (
        .clk_i(shift_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(reload_tgl),
        .q_o(reload_s)
    );

    // status packet assembly
    always_comb begin
        status_word = '0;
        status_word[`LSL_ST_OPEN_HI:`LSL_ST_OPEN_LO] = open_s;
        status_word[`LSL_ST_TEF_BIT] = tef_s;
        status_word[`LSL_ST_TWF_BIT] = twf_s;
        status_word[`LSL_ST_DC_HI:`LSL_ST_DC_LO] = dot_correction_value_o;
        status_word[`LSL_ST_OPEN2_HI:`LSL_ST_OPEN2_LO] = open_s;
        status_word[`LSL_ST_SHORT_HI:`LSL_ST_SHORT_LO] = short_s;
    end

    // latch edge detect; the idle shift register is captured, then loaded
    always_comb begin
        latch_rise = latch_s && !latch_prev;
        next_latch_prev = latch_s;
        next_mode = mode_s ? LSL_MODE_DC : LSL_MODE_GS;
        next_snap_shift = snap_shift;
        next_snap_busy = 1'b0;
        next_snap_mode = snap_mode;
        next_reload_tgl = reload_tgl;
        next_status_hold = status_hold;
        load_gs = 1'b0;
        load_dc = 1'b0;
        // no serial clock runs while the strobe is high, so the packet has
        // stood still for two core cycles when the synchronised rise reads it
        if (latch_rise && !snap_busy) begin
            next_snap_shift = shift_reg;
            next_snap_busy = 1'b1;
            next_snap_mode = mode_s;
        end
        if (snap_busy) begin
            if (snap_mode) begin
                load_dc = 1'b1;
            end else begin
                load_gs = 1'b1;
                next_status_hold = status_word;
                next_reload_tgl = !reload_tgl;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latch_prev <= 1'b0;
            mode_o <= LSL_MODE_GS;
            snap_busy <= 1'b0;
            snap_mode <= 1'b0;
            reload_tgl <= 1'b0;
            status_hold <= '0;
            snap_shift <= '0;
        end else begin
            latch_prev <= next_latch_prev;
            mode_o <= next_mode;
            snap_busy <= next_snap_busy;
            snap_mode <= next_snap_mode;
            reload_tgl <= next_reload_tgl;
            status_hold <= next_status_hold;
            snap_shift <= next_snap_shift;
        end
    end

    lsl_regs u_regs (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_gs_i(load_gs),
        .load_dc_i(load_dc),
        .gs_data_i(snap_shift),
        .dc_data_i(snap_shift[`LSL_DC_PACKET_BITS-1:0]),
        .greyscale_value_o(greyscale_value_o),
        .dot_correction_value_o(dot_correction_value_o)
    );

    // link side: shift, reload with status on the third edge after a latch
    always_comb begin
        next_shift_reg = {shift_reg[`LSL_GS_PACKET_BITS-2:0], serial_in_i};
        next_reload_seen = reload_s;
        if (reload_s != reload_seen) begin
            next_shift_reg = status_hold;
        end
    end

    always_ff @(posedge shift_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg <= '0;
            reload_seen <= 1'b0;
        end else begin
            shift_reg <= next_shift_reg;
            reload_seen <= next_reload_seen;
        end
    end

    // msb leaves first; in dc mode the 96-bit register ends at bit 95
    always_comb begin
        serial_out_o = (mode_s ? shift_reg[`LSL_DC_PACKET_BITS-1]
                               : shift_reg[`LSL_GS_PACKET_BITS-1]);
    end
endmodule

//--- sim/lsl_loader_properties.sv
// checker of loader outputs: reset state, mode tracking, whole loads
// assumes a bind onto lsl_loader; every check runs on clk_i
module lsl_loader_chk import lsl_pkg::*; #(
    parameter int CHANNELS = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mode_i,
    input wire logic serial_out_o,
    input wire lsl_gs_all_t greyscale_value_o,
    input wire lsl_dc_all_t dot_correction_value_o,
    input wire lsl_mode_t mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // state seen at reset release
    chk_gs_reset: assert property ($rose(rst_n_i) |-> greyscale_value_o == '1)
        else $error("greyscale not reset");
    chk_dc_reset: assert property ($rose(rst_n_i) |-> dot_correction_value_o == '1)
        else $error("dot correction not reset");
    chk_idle_reset: assert property ($rose(rst_n_i) |->
        !serial_out_o && mode_o == LSL_MODE_GS) else $error("output or mode not reset");
    // loads only in the matching mode, all channels in one step
    chk_gs_mode: assert property ($changed(greyscale_value_o) |->
        mode_o == LSL_MODE_GS) else $error("greyscale load in wrong mode");
    chk_dc_mode: assert property ($changed(dot_correction_value_o) |->
        mode_o == LSL_MODE_DC) else $error("dot correction load in wrong mode");
    chk_gs_whole: assert property ($changed(greyscale_value_o) |=>
        $stable(greyscale_value_o) [*8]) else $error("greyscale changed in pieces");
    chk_dc_whole: assert property ($changed(dot_correction_value_o) |=>
        $stable(dot_correction_value_o) [*8]) else $error("dot correction in pieces");
    // mode output follows a steady pin within three cycles
    chk_mode_dc: assert property (mode_i [*4] |-> mode_o == LSL_MODE_DC)
        else $error("mode output not dot correction");
    chk_mode_gs: assert property ((!mode_i) [*4] |-> mode_o == LSL_MODE_GS)
        else $error("mode output not greyscale");
    cover property ($changed(greyscale_value_o));
    cover property ($changed(dot_correction_value_o));
    cover property (mode_o == LSL_MODE_DC ##1 mode_o == LSL_MODE_GS);
endmodule

bind lsl_loader lsl_loader_chk #(.CHANNELS(CHANNELS)) u_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mode_i(mode_i), .serial_out_o(serial_out_o),
    .greyscale_value_o(greyscale_value_o), .dot_correction_value_o(dot_correction_value_o),
    .mode_o(mode_o)
);

//--- sim/lsl_ctrl_model.sv
// controller model: shifts packets msb first on its own 30 ns serial clock
// assumes the loader samples serial_in on the rising serial clock edge
module lsl_ctrl_model (
    output logic shift_clk_o,
    output logic serial_in_o,
    output logic latch_o,
    input wire logic serial_out_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // serial clock stands still between frames
    initial begin
        shift_clk_o = 1'b0;
        serial_in_o = 1'b0;
        latch_o = 1'b0;
    end
    // filler byte then packet; rx holds serial_out seen before each rise
    task automatic send(input lsl_pkg::lsl_shift_t pkt, output logic [199:0] rx);
        logic [199:0] bits;
        bits = {8'h5a, pkt};
        for (int i = 199; i >= 0; i--) begin
            serial_in_o = bits[i];
            #12;
            rx[i] = serial_out_i;
            #3 shift_clk_o = 1'b1;
            #15 shift_clk_o = 1'b0;
        end
        serial_in_o = ~serial_in_o; // released line shows no stale bit
        latch_o = 1'b1;
        // serial clock stays still for the whole strobe
        #150 latch_o = 1'b0;
    endtask
endmodule

//--- sim/lsl_loader_bench.sv
// bench of the serial loader with controller model and bound checker
// assumes lsl_loader, lsl_loader_chk and lsl_ctrl_model compiled first
module lsl_loader_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import lsl_pkg::*;
    logic clk_i, rst_n_i, mode_i, te, tw, sclk, serial_in, lat, serial_out;
    logic [15:0] op, sh;
    lsl_shift_t p, st, got;
    lsl_gs_all_t gs;
    lsl_dc_all_t dc, dcv;
    lsl_mode_t md;
    logic [199:0] rx;
    int fails, compares;
    lsl_loader DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .shift_clk_i(sclk), .serial_in_i(serial_in),
        .latch_strobe_i(lat), .mode_i(mode_i), .open_led_flags_i(op), .short_led_flags_i(sh),
        .thermal_error_flag_i(te), .thermal_warning_flag_i(tw), .serial_out_o(serial_out),
        .greyscale_value_o(gs), .dot_correction_value_o(dc), .mode_o(md));
    lsl_ctrl_model ctl (.shift_clk_o(sclk), .serial_in_o(serial_in), .latch_o(lat), .serial_out_i(serial_out));
    // 40 MHz core clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic finish_test();
        if (fails == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [191:0] g, input logic [191:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // bounded wait for a register load, then compare
    task automatic wait_val(input logic [191:0] e, input bit is_dc);
        got = is_dc ? {96'h0, dc} : gs;
        for (int n = 0; n < 100 && got !== e; n++) begin
            @(negedge clk_i);
            got = is_dc ? {96'h0, dc} : gs;
        end
        chk(got, e);
        if (got !== e) finish_test();
    endtask
    function automatic lsl_shift_t rnd();
        lsl_shift_t r;
        for (int k = 0; k < 6; k++) r[k*32 +: 32] = $urandom;
        return r;
    endfunction
    // status expected after a greyscale latch, reserved bits zero
    function automatic lsl_shift_t status(input lsl_dc_all_t d);
        return {op, te, tw, 6'h0, d, 40'h0, op, sh};
    endfunction
    // cuts a hang short
    initial begin
        #2ms;
        fails++;
        finish_test();
    end
    // reset, two dot-correction loads, then greyscale loads with status readback
    initial begin
        rst_n_i = 1'b0;
        mode_i = 1'b0;
        {op, sh} = 32'h0;
        {te, tw} = 2'b10;
        fails = 0;
        compares = 0;
        st = '0;
        void'($urandom(95));
        repeat (10) @(posedge clk_i);
        @(negedge clk_i) rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk(gs, {16{12'hfff}});
        chk({96'h0, dc}, {96'h0, {16{6'h3f}}});
        chk({191'h0, md}, {191'h0, LSL_MODE_GS});
        mode_i = 1'b1;
        repeat (6) @(negedge clk_i);
        for (int r = 0; r < 2; r++) begin
            p = rnd();
            if (r == 0) p[95:0] = '0;
            dcv = p[95:0];
            ctl.send(p, rx);
            wait_val({96'h0, dcv}, 1'b1);
            chk(gs, {16{12'hfff}});
        end
        mode_i = 1'b0;
        repeat (6) @(negedge clk_i);
        for (int i = 0; i < 5; i++) begin
            p = rnd();
            if (i == 0) p = '0;
            if (i == 1) p = '1;
            ctl.send(p, rx);
            // status enters on the third serial edge, first seen before the fourth
            got = rx[196 -: 192];
            if (i > 0) chk(got, st);
            wait_val(p, 1'b0);
            chk({96'h0, dc}, {96'h0, dcv});
            repeat (8) @(negedge clk_i);
            st = status(dcv);
            {op, sh} = $urandom;
            {te, tw} = 2'($urandom);
        end
        finish_test();
    end
endmodule
